/* File: rtl/cpec_top.v */
// Core performance counters: three fixed counters and one event-selected counter.
// Assumes event strobes come from core logic on mclk; ref_tick and the
// stop-clock level come from outside and are synchronised here.
`timescale 1ns/1ps
`include "cpec_map.vh"

// Contract
// - Host-mode select counts retires in root mode only
// - D2H/10H counts other alias-table serialization stalls
// - Counter 309H adds one per retired instruction
// - Multi-op instruction counts at last micro-op
// - Retire counting continues during interrupts, traps
// - Counter 30AH counts unhalted core clock cycles
// - Core cycle count follows actual core clock
// - Counter 30BH counts reference cycles, not halted/stopped
// - Halt entered by halt or monitor-wait instruction
// - Reference count runs at time-stamp rate
// - Reference count keeps constant ratio to bus cycles
// - 03H/02H counts loads awaiting store address
// - 03H/04H counts loads awaiting same-address store data
// - Load-block counts never below blocked loads
// - 03H/08H counts partial store overlap blocks
// - Overlap counts small load unaligned to store
// - Overlap counts misaligned four/eight-byte loads
module cpec_top (
	input wire mclk,
	input wire rstn,
	input wire ce,
	input wire uop_retire,
	input wire uop_last,
	input wire host_mode,
	input wire halt_instruction,
	input wire monitor_wait_instruction,
	input wire wake,
	input wire thermal_stop_clock,
	input wire ref_tick,
	input wire alias_table_serialization_stall_event,
	input wire load_wait_store_address_event,
	input wire load_wait_store_value_event,
	input wire store_partial_overlap,
	input wire store_size_aligned,
	input wire store_covers_load,
	input wire [3:0] load_size,
	input wire load_aligned_to_store,
	input wire load_misaligned,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg halted
);

	// Byte lane merge for one 32-bit half of a counter
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
			end
		end
	endfunction

	// Word index from byte address: upper word of a counter sits 0x100 indices above the low word
	function [12:0] widx;
		input [31:0] a;
		begin
			widx = a[14:2];
		end
	endfunction

	// Word index of the low word of counter n; 3 is the event-selected counter
	function [12:0] lo_idx;
		input [1:0] n;
		begin
			if (n == 2'h3) begin
				lo_idx = {1'b0, `CPEC_IDX_GP_CNT};
			end else begin
				lo_idx = {1'b0, `CPEC_IDX_RETIRED + {10'h000, n}};
			end
		end
	endfunction

	// Upper word sits one page of 0x100 words above the low word
	function [12:0] hi_idx;
		input [1:0] n;
		begin
			hi_idx = lo_idx(n) + 13'h0100;
		end
	endfunction

	// Only aligned words in the low window decode, so high address bits cannot alias
	function in_win;
		input [31:0] a;
		begin
			in_win = (a[31:15] == 17'h00000) && (a[1:0] == 2'h0);
		end
	endfunction

	// Synchronisers for inputs from outside mclk
	reg ref_s1_reg;
	reg ref_s2_reg;
	reg ref_s3_reg;
	reg stop_s1_reg;
	reg stop_s2_reg;
	// Tick: two stages against metastability, a third for the edge detect
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ref_s1_reg <= 1'b0;
			ref_s2_reg <= 1'b0;
			ref_s3_reg <= 1'b0;
		end else if (ce) begin
			ref_s1_reg <= ref_tick;
			ref_s2_reg <= ref_s1_reg;
			ref_s3_reg <= ref_s2_reg;
		end
	end

	// Stop-clock level: only the second stage is read by logic
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			stop_s1_reg <= 1'b0;
			stop_s2_reg <= 1'b0;
		end else if (ce) begin
			stop_s1_reg <= thermal_stop_clock;
			stop_s2_reg <= stop_s1_reg;
		end
	end
	// One count per time-stamp tick edge, independent of core frequency
	wire ref_edge = ref_s2_reg & ~ref_s3_reg;

	// Halt state
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			halted <= 1'b0;
		end else if (ce) begin
			if (halt_instruction | monitor_wait_instruction) begin
				halted <= 1'b1;
			end else if (wake) begin
				halted <= 1'b0;
			end
		end
	end

	// Qualified events
	wire inst_ret = uop_retire & uop_last;

	// Load size classes for the aligned-store overlap cases
	function small_load;
		input [3:0] sz;
		begin
			small_load = (sz == 4'h1) | (sz == 4'h2);
		end
	endfunction

	function wide_load;
		input [3:0] sz;
		begin
			wide_load = (sz == 4'h4) | (sz == 4'h8);
		end
	endfunction

	wire covered = store_size_aligned & store_covers_load;
	wire ovl_partial = store_partial_overlap;
	wire ovl_small = covered & small_load(load_size) & !load_aligned_to_store;
	wire ovl_wide = covered & wide_load(load_size) & load_misaligned;
	wire overlap_hit = ovl_partial | ovl_small | ovl_wide;

	reg [31:0] sel_reg;
	wire [7:0] sel_evt = sel_reg[`CPEC_SEL_EVT_HI:`CPEC_SEL_EVT_LO];
	wire [7:0] sel_um = sel_reg[`CPEC_SEL_UMASK_HI:`CPEC_SEL_UMASK_LO];
	reg gp_hit;
	always @* begin
		gp_hit = 1'b0;
		case (sel_evt)
		`CPEC_EVT_RETIRED: begin
			if (sel_um == `CPEC_UM_HOST) begin
				gp_hit = inst_ret & host_mode;
			end
		end
		`CPEC_EVT_RAT: begin
			if (sel_um == `CPEC_UM_RAT_OTHER) begin
				gp_hit = alias_table_serialization_stall_event;
			end
		end
		`CPEC_EVT_LOAD_BLK: begin
			// Counted every blocked cycle, so a retried load may count twice
			case (sel_um)
			`CPEC_UM_LB_ADDR: gp_hit = load_wait_store_address_event;
			`CPEC_UM_LB_DATA: gp_hit = load_wait_store_value_event;
			`CPEC_UM_LB_OVERLAP: gp_hit = overlap_hit;
			default: gp_hit = 1'b0;
			endcase
		end
		default: gp_hit = 1'b0;
		endcase
	end

	// AXI4-Lite write channel
	reg aw_got_reg;
	reg w_got_reg;
	reg [31:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
	wire wr_go = aw_got_reg & w_got_reg;
	wire [12:0] wi = widx(awaddr_reg);
	wire [12:0] ri = widx(s_axi_araddr);
	wire wr_in = in_win(awaddr_reg);
	wire rd_in = in_win(s_axi_araddr);

	// Counters: low word at index, upper word at index plus 0x100
	reg [63:0] cnt_reg [0:3];
	reg [63:0] cnt_next [0:3];
	reg [3:0] inc;
	reg wr_ok;
	integer kw;
	integer kc;
	integer kr;
	always @* begin
		inc[0] = inst_ret;
		inc[1] = !halted;
		inc[2] = ref_edge & !halted & !stop_s2_reg;
		inc[3] = gp_hit;
		wr_ok = 1'b0;
		for (kw = 0; kw < 4; kw = kw + 1) begin
			cnt_next[kw] = cnt_reg[kw] + {63'd0, inc[kw]};
		end
		// A software write wins over that cycle's increment, word by word
		if (wr_go && wr_in) begin
			for (kw = 0; kw < 4; kw = kw + 1) begin
				if (wi == lo_idx(kw[1:0])) begin
					wr_ok = 1'b1;
					cnt_next[kw][31:0] = merge(cnt_reg[kw][31:0], wdata_reg, wstrb_reg);
				end
				if (wi == hi_idx(kw[1:0])) begin
					wr_ok = 1'b1;
					cnt_next[kw][63:32] = merge(cnt_reg[kw][63:32], wdata_reg, wstrb_reg);
				end
			end
			if (wi == {1'b0, `CPEC_IDX_GP_SEL}) begin
				wr_ok = 1'b1;
			end
		end
	end

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (kc = 0; kc < 4; kc = kc + 1) begin
				cnt_reg[kc] <= `CPEC_CNT_RESET;
			end
			sel_reg <= `CPEC_SEL_RESET;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 32'h00000000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CPEC_RESP_OKAY;
		end else if (ce) begin
			for (kc = 0; kc < 4; kc = kc + 1) begin
				cnt_reg[kc] <= cnt_next[kc];
			end
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `CPEC_RESP_OKAY : `CPEC_RESP_SLVERR;
				if (wi == {1'b0, `CPEC_IDX_GP_SEL}) begin
					sel_reg <= merge(sel_reg, wdata_reg, wstrb_reg);
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one-cycle answer, data sampled from the live counter
	assign s_axi_arready = !s_axi_rvalid;
	reg [31:0] rd_val;
	reg rd_ok;
	// Two word reads of a running counter are not atomic; software rereads the high word
	always @* begin
		rd_val = 32'h00000000;
		rd_ok = 1'b0;
		if (rd_in) begin
			for (kr = 0; kr < 4; kr = kr + 1) begin
				if (ri == lo_idx(kr[1:0])) begin
					rd_ok = 1'b1;
					rd_val = cnt_reg[kr][31:0];
				end
				if (ri == hi_idx(kr[1:0])) begin
					rd_ok = 1'b1;
					rd_val = cnt_reg[kr][63:32];
				end
			end
			if (ri == {1'b0, `CPEC_IDX_GP_SEL}) begin
				rd_ok = 1'b1;
				rd_val = sel_reg;
			end
		end
	end

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `CPEC_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_ok ? `CPEC_RESP_OKAY : `CPEC_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // cpec_top

/* File: rtl/cpec_map.vh */
// Register map, event encodings and reset values of the core event counter block.
// Assumes inclusion by rtl/cpec_top.v and by the directed bench.
`ifndef CPEC_MAP_VH
`define CPEC_MAP_VH
// Printed register indices; byte address is four times the index
`define CPEC_IDX_RETIRED 12'h309
`define CPEC_IDX_CORE_CYC 12'h30a
`define CPEC_IDX_REF_CYC 12'h30b
// Own registers: general-purpose counter and its event select
`define CPEC_IDX_GP_SEL 12'h30c
`define CPEC_IDX_GP_CNT 12'h30d
// Event select field positions
`define CPEC_SEL_EVT_LO 0
`define CPEC_SEL_EVT_HI 7
`define CPEC_SEL_UMASK_LO 8
`define CPEC_SEL_UMASK_HI 15
// Event numbers and unit masks
`define CPEC_EVT_RETIRED 8'hc0
`define CPEC_UM_HOST 8'h08
`define CPEC_EVT_RAT 8'hd2
`define CPEC_UM_RAT_OTHER 8'h10
`define CPEC_EVT_LOAD_BLK 8'h03
`define CPEC_UM_LB_ADDR 8'h02
`define CPEC_UM_LB_DATA 8'h04
`define CPEC_UM_LB_OVERLAP 8'h08
// Reset values
`define CPEC_CNT_RESET 64'h0000000000000000
`define CPEC_SEL_RESET 32'h00000000
// Bus responses
`define CPEC_RESP_OKAY 2'b00
`define CPEC_RESP_SLVERR 2'b10
`endif

/* File: tb/cpec_checker.sv */
// Bus and halt-state checks on the cpec_top ports.
// Assumes ce is held high by the bench.
`timescale 1ns/1ps
module cpec_checker (
	input logic mclk,
	input logic rstn,
	input logic halt_instruction,
	input logic monitor_wait_instruction,
	input logic wake,
	input logic halted,
	input logic s_axi_awready,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [31:0] s_axi_rdata
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	sequence ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence r_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	sequence go_halt;
		(halt_instruction || monitor_wait_instruction) && !wake;
	endsequence
	a_rd_answer: assert property (ar_take |=> s_axi_rvalid)
		else $error("read not answered");
	a_rd_hold: assert property (r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_halt_enter: assert property (go_halt |=> halted)
		else $error("halt not entered");
	a_halt_stay: assert property (halted && !wake |=> halted)
		else $error("halt left early");
	a_wake_exit: assert property (wake && !go_halt |=> !halted)
		else $error("halt not left");
endmodule // cpec_checker

/* File: tb/cpec_tb_top.sv */
// Directed bench for cpec_top: AXI4-Lite tasks and event strobes.
// Assumes rtl/ on the include path; event strobes held one to three cycles.
`timescale 1ns/1ps
`include "cpec_map.vh"
module cpec_tb_top;
	logic mclk = 0, rstn = 0, uop_retire = 0, uop_last = 0, host_mode = 0, wake = 0;
	logic halt_instruction = 0, monitor_wait_instruction = 0, thermal_stop_clock = 0;
	logic ref_tick = 0, alias_table_serialization_stall_event = 0, store_partial_overlap = 0;
	logic load_wait_store_address_event = 0, load_wait_store_value_event = 0;
	logic store_size_aligned = 0, store_covers_load = 0, load_aligned_to_store = 0;
	logic load_misaligned = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_bready = 1, s_axi_rready = 1;
	logic [3:0] load_size = 4'h1, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, halted;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int error_cnt = 0, tests_run = 0;
	cpec_top dut_u (.ce(1'b1), .*);
	initial forever #50 mclk = ~mclk;
	task wrap_up;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input [33:0] s, input [33:0] e, input string n);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	// Valid and payload stand until the rising edge that samples ready high
	task wr(input [31:0] a, input [31:0] d);
		logic ta, tw;
		ta = 0;
		tw = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (!(ta && tw)) begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) begin
				ta = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				tw = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge mclk); while (!s_axi_bvalid);
	endtask
	task rc(input [31:0] a, input [33:0] e, input string n);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge mclk); while (!s_axi_rvalid);
		chk({s_axi_rresp, s_axi_rdata}, e, n);
	endtask
	task ret(input l);
		uop_retire <= 1;
		uop_last <= l;
		@(posedge mclk);
		uop_retire <= 0;
		@(posedge mclk);
	endtask
	task tick(input int n);
		repeat (n) begin
			ref_tick <= 1;
			repeat (3) @(posedge mclk);
			ref_tick <= 0;
			repeat (3) @(posedge mclk);
		end
	endtask
	initial begin
		#200000;
		error_cnt++;
		wrap_up;
	end
	initial begin
		repeat (5) @(posedge mclk);
		rstn <= 1;
		@(posedge mclk);
		rc(32'hc24, 0, "ret rst");
		wr(32'hc24, 5);
		ret(0);
		ret(1);
		rc(32'hc24, 6, "ret last");
		wr(32'hc28, 0);
		rc(32'hc28, 1, "cyc run");
		halt_instruction <= 1;
		@(posedge mclk);
		halt_instruction <= 0;
		wr(32'hc28, 0);
		wr(32'hc2c, 0);
		tick(2);
		chk(halted, 1, "halt");
		rc(32'hc28, 0, "cyc halt");
		rc(32'hc2c, 0, "ref halt");
		wake <= 1;
		@(posedge mclk);
		wake <= 0;
		monitor_wait_instruction <= 1;
		@(posedge mclk);
		monitor_wait_instruction <= 0;
		@(negedge mclk);
		chk(halted, 1, "monitor_wait_instruction");
		@(posedge mclk);
		wake <= 1;
		@(posedge mclk);
		wake <= 0;
		wr(32'hc2c, 0);
		tick(3);
		rc(32'hc2c, 3, "ref run");
		thermal_stop_clock <= 1;
		repeat (4) @(posedge mclk);
		wr(32'hc2c, 0);
		tick(2);
		rc(32'hc2c, 0, "ref stop");
		thermal_stop_clock <= 0;
		wr(32'hc30, {16'h0, `CPEC_UM_HOST, `CPEC_EVT_RETIRED});
		wr(32'hc34, 0);
		ret(1);
		host_mode <= 1;
		ret(1);
		rc(32'hc34, 1, "host");
		host_mode <= 0;
		wr(32'hc30, {16'h0, `CPEC_UM_LB_ADDR, `CPEC_EVT_LOAD_BLK});
		wr(32'hc34, 0);
		load_wait_store_address_event <= 1;
		repeat (3) @(posedge mclk);
		load_wait_store_address_event <= 0;
		rc(32'hc34, 3, "ld addr");
		wr(32'hc30, {16'h0, `CPEC_UM_LB_DATA, `CPEC_EVT_LOAD_BLK});
		wr(32'hc34, 0);
		load_wait_store_value_event <= 1;
		repeat (2) @(posedge mclk);
		load_wait_store_value_event <= 0;
		rc(32'hc34, 2, "ld data");
		wr(32'hc30, {16'h0, `CPEC_UM_RAT_OTHER, `CPEC_EVT_RAT});
		wr(32'hc34, 0);
		alias_table_serialization_stall_event <= 1;
		repeat (2) @(posedge mclk);
		alias_table_serialization_stall_event <= 0;
		rc(32'hc34, 2, "rat stall");
		wr(32'hc30, {16'h0, `CPEC_UM_LB_OVERLAP, `CPEC_EVT_LOAD_BLK});
		wr(32'hc34, 0);
		store_partial_overlap <= 1;
		@(posedge mclk);
		store_partial_overlap <= 0;
		rc(32'hc34, 1, "ovl part");
		store_size_aligned <= 1;
		store_covers_load <= 1;
		load_size <= 4'h2;
		@(posedge mclk);
		load_aligned_to_store <= 1;
		@(posedge mclk);
		load_aligned_to_store <= 0;
		store_size_aligned <= 0;
		rc(32'hc34, 2, "ovl small");
		store_size_aligned <= 1;
		load_size <= 4'h8;
		load_misaligned <= 1;
		@(posedge mclk);
		load_misaligned <= 0;
		@(posedge mclk);
		store_size_aligned <= 0;
		rc(32'hc34, 3, "ovl wide");
		wr(32'hc24, 32'hffffffff);
		wr(32'h1024, 32'hffffffff);
		ret(1);
		rc(32'hc24, 0, "wrap lo");
		rc(32'h1024, 0, "wrap hi");
		rc(32'h0, {`CPEC_RESP_SLVERR, 32'h0}, "unmapped");
		wrap_up;
	end
endmodule // cpec_tb_top
bind cpec_top cpec_checker chk_u (.*);
